// ===== src/reset_control_and_wakeup.sv
// Reset sequencer, boot strap latch, wake-up control and supply flags.
// Assumes async pins and detectors; Wishbone slave on clk_i.
// How it works
// - Causes: power-on, pin, watchdog, wake-up, brownout.
// - Straps latch at sequence end, frozen until power-on, pin or brownout reset.
// - Core supply low: brownout reset, then power-on sequence.
// - Brownout detector always enabled.
// - Pad supply low sets flag; NMI only if enabled.
// - Power-down: only brownout detector on; pad one off at 3.3 V.
// - Regulator reset held 300 us after core supply good.
// - PLL off until regulator and oscillator ok; CPU waits clock.
// - Execution starts at address zero.
// - Low reset pin: hardware reset, then power-on sequence.
// - Pin reset ends idle or power-down mode.
// - Watchdog requests NMI, then resets.
// - Watchdog reset sets its flag.
// - Watchdog sequence skips regulator and clock waits.
// - Wake source: receive line, interrupt zero or either.
// - Wake reset select: wake with or without reset.
// - Wake flag reports wake-up.
// - Ports tristate while brownout persists.
// - RAM kept on wake, watchdog, pin reset; lost on power-on, brownout.
// - Any wake turns regulator on; wake reset also reruns regulator hold.
// - Power-down: main regulator off, low power one on.
// - Straps decode to user, JTAG user, loader or debug.
// - Wake source field: none, receive, interrupt zero, either.
// - Power mode reset value depends on cause.
// - Pin reset flag: hardware sets, software clears.
module reset_control_and_wakeup
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Asynchronous pins and detectors
    input  wire logic        ext_reset_n_i,
    input  wire logic        por_good_i,
    input  wire logic        core_supply_low_i,
    input  wire logic        pad_supply_low_i,
    input  wire logic        pad_is_3v3_i,
    input  wire logic        osc_running_i,
    input  wire logic        clk_stable_i,
    input  wire logic        boot_mode_pin_i,
    input  wire logic        tms_pin_i,
    input  wire logic        boot_select_pin_zero_i,
    input  wire logic        rxd_i,
    input  wire logic        ext_irq_zero_input_i,
    // Same-domain inputs
    input  wire logic        wdog_nmi_req_i,
    input  wire logic        wdog_timeout_i,
    input  wire logic        idle_i,
    // Outputs
    output logic             cpu_reset_o,
    output logic [15:0]      start_addr_o,
    output logic [1:0]       boot_mode_o,
    output logic             main_reg_en_o,
    output logic             lp_reg_en_o,
    output logic             reg_reset_o,
    output logic             pll_out_en_o,
    output logic             pad_det_en_o,
    output logic             core_det_en_o,
    output logic             ports_tristate_o,
    output logic             ram_valid_o,
    output logic             nmi_o,
    output logic             idle_exit_o,
    output logic             power_down_o
);

    // ====================
    // Synchronisers
    localparam int NSYNC = 12;
    logic [NSYNC-1:0] async_w;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    assign async_w = {ext_reset_n_i, por_good_i, core_supply_low_i,
                      pad_supply_low_i, pad_is_3v3_i, osc_running_i,
                      clk_stable_i, boot_mode_pin_i, tms_pin_i,
                      boot_select_pin_zero_i, rxd_i, ext_irq_zero_input_i};

    always_ff @(posedge clk_i)
    begin
        s1_q <= async_w;
        s2_q <= s1_q;
    end

    logic pin_rst_w;
    logic por_good_w;
    logic brown_w;
    logic pad_low_w;
    logic pad_3v3_w;
    logic osc_ok_w;
    logic clk_ok_w;
    logic [2:0] straps_w;
    logic rxd_w;
    logic ext0_w;
    assign pin_rst_w  = ~s2_q[11];
    assign por_good_w = s2_q[10];
    assign brown_w    = s2_q[9];
    assign pad_low_w  = s2_q[8];
    assign pad_3v3_w  = s2_q[7];
    assign osc_ok_w   = s2_q[6];
    assign clk_ok_w   = s2_q[5];
    assign straps_w   = s2_q[4:2];
    assign rxd_w      = s2_q[1];
    assign ext0_w     = s2_q[0];

    // ====================
    // State and registers
    rst_seq_pkg::state_t state_q;
    rst_seq_pkg::state_t state_d;
    logic [rst_seq_pkg::CNT_W-1:0] cnt_q;
    logic [rst_seq_pkg::CNT_W-1:0] cnt_d;
    logic [7:0] pmc_q;
    logic [7:0] misc_q;
    logic [7:0] nmi_q;
    logic [2:0] straps_q;
    logic       rxd_q;
    logic       ext0_q;
    logic       ram_ok_q;
    rst_seq_pkg::cause_t cause_q;

    // ====================
    // Bus decode
    logic req_w;
    logic wr_w;
    logic wr_pmc_w;
    logic wr_misc_w;
    logic wr_nmi_w;
    logic hit_w;
    assign req_w     = cyc_i & stb_i & ~ack_o;
    assign wr_w      = req_w & we_i & sel_i[0];
    assign wr_pmc_w  = wr_w & (adr_i == rst_seq_pkg::PMC_OFS);
    assign wr_misc_w = wr_w & (adr_i == rst_seq_pkg::MISC_OFS);
    assign wr_nmi_w  = wr_w & (adr_i == rst_seq_pkg::NMI_OFS);
    assign hit_w     = (adr_i == rst_seq_pkg::PMC_OFS)
                     | (adr_i == rst_seq_pkg::MISC_OFS)
                     | (adr_i == rst_seq_pkg::NMI_OFS)
                     | (adr_i == rst_seq_pkg::STAT_OFS);

    logic [7:0] rd_w;
    assign rd_w = (adr_i == rst_seq_pkg::PMC_OFS)  ? pmc_q
                : (adr_i == rst_seq_pkg::MISC_OFS) ? misc_q
                : (adr_i == rst_seq_pkg::NMI_OFS)  ? nmi_q
                : (adr_i == rst_seq_pkg::STAT_OFS)
                    ? {2'h0, ram_ok_q, cause_q, boot_mode_o}
                : 8'h00;

    // ====================
    // Causes and wake detection
    logic full_rst_w;
    logic rxd_fall_w;
    logic ext0_fall_w;
    logic wake_w;
    logic [1:0] ws_w;
    logic asleep_w;
    assign full_rst_w  = ~por_good_w | brown_w | pin_rst_w;
    assign ws_w        = pmc_q[rst_seq_pkg::WS_LSB +: 2];
    assign rxd_fall_w  = rxd_q & ~rxd_w;
    assign ext0_fall_w = ext0_q & ~ext0_w;
    assign asleep_w    = (state_q == rst_seq_pkg::ST_SLEEP);
    assign wake_w = asleep_w
        & (((ws_w == rst_seq_pkg::WS_RXD) & rxd_fall_w)
        | ((ws_w == rst_seq_pkg::WS_EXT) & ext0_fall_w)
        | ((ws_w == rst_seq_pkg::WS_BOTH) & (rxd_fall_w | ext0_fall_w)));
    logic wake_rst_w;
    assign wake_rst_w = wake_w & pmc_q[rst_seq_pkg::WAKE_RESET_SEL_BIT];
    logic pd_req_w;
    assign pd_req_w = wr_pmc_w & dat_i[rst_seq_pkg::PD_BIT];

    // ====================
    // Sequencer next state
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        if (full_rst_w)
        begin
            state_d = rst_seq_pkg::ST_HOLD;
            cnt_d   = '0;
        end
        else
        begin
            unique case (state_q)
                rst_seq_pkg::ST_HOLD:
                begin
                    state_d = rst_seq_pkg::ST_REG;
                    cnt_d   = '0;
                end
                rst_seq_pkg::ST_REG:
                begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == rst_seq_pkg::CNT_W'(
                        rst_seq_pkg::REG_HOLD_CYCLES - 1))
                    begin
                        state_d = rst_seq_pkg::ST_CLK;
                        cnt_d   = '0;
                    end
                end
                rst_seq_pkg::ST_CLK:
                begin
                    if (osc_ok_w & clk_ok_w)
                        cnt_d = cnt_q + 1'b1;
                    if (cnt_q == rst_seq_pkg::CNT_W'(
                        rst_seq_pkg::CLK_WAIT_CYCLES - 1))
                        state_d = rst_seq_pkg::ST_RUN;
                end
                rst_seq_pkg::ST_WDOG:
                begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == rst_seq_pkg::CNT_W'(
                        rst_seq_pkg::WDOG_RST_CYCLES - 1))
                        state_d = rst_seq_pkg::ST_RUN;
                end
                rst_seq_pkg::ST_RUN:
                begin
                    cnt_d = '0;
                    if (wdog_timeout_i)
                        state_d = rst_seq_pkg::ST_WDOG;
                    else if (pd_req_w)
                        state_d = rst_seq_pkg::ST_SLEEP;
                end
                rst_seq_pkg::ST_SLEEP:
                begin
                    cnt_d = '0;
                    if (wake_rst_w)
                        state_d = rst_seq_pkg::ST_REG;
                    else if (wake_w)
                        state_d = rst_seq_pkg::ST_RUN;
                end
            endcase
        end
    end

    logic seq_done_w;
    assign seq_done_w = (state_d == rst_seq_pkg::ST_RUN)
                      & (state_q != rst_seq_pkg::ST_RUN)
                      & (state_q != rst_seq_pkg::ST_SLEEP);

    // ====================
    // Sequencer and status registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q  <= rst_seq_pkg::ST_HOLD;
            cnt_q    <= '0;
            rxd_q    <= 1'b1;
            ext0_q   <= 1'b1;
            straps_q <= 3'h0;
            cause_q  <= rst_seq_pkg::CAUSE_POR;
            ram_ok_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            rxd_q   <= rxd_w;
            ext0_q  <= ext0_w;
            if (seq_done_w & ((cause_q == rst_seq_pkg::CAUSE_POR)
                | (cause_q == rst_seq_pkg::CAUSE_PIN)
                | (cause_q == rst_seq_pkg::CAUSE_BOR)))
                straps_q <= straps_w;
            if (~por_good_w)
                cause_q <= rst_seq_pkg::CAUSE_POR;
            else if (brown_w)
                cause_q <= rst_seq_pkg::CAUSE_BOR;
            else if (pin_rst_w)
                cause_q <= rst_seq_pkg::CAUSE_PIN;
            else if (state_d == rst_seq_pkg::ST_WDOG
                     & state_q == rst_seq_pkg::ST_RUN)
                cause_q <= rst_seq_pkg::CAUSE_WDOG;
            else if (wake_rst_w)
                cause_q <= rst_seq_pkg::CAUSE_WAKE;
            if (~por_good_w | brown_w)
                ram_ok_q <= 1'b0;
            else if (seq_done_w & (cause_q != rst_seq_pkg::CAUSE_POR)
                     & (cause_q != rst_seq_pkg::CAUSE_BOR))
                ram_ok_q <= 1'b1;
        end
    end

    // ====================
    // Software registers
    logic [7:0] pmc_sw_w;
    assign pmc_sw_w = {pmc_q[rst_seq_pkg::WARN_BIT],
        pmc_q[rst_seq_pkg::WDFLAG_BIT] & dat_i[rst_seq_pkg::WDFLAG_BIT],
        pmc_q[rst_seq_pkg::WKFLAG_BIT] & dat_i[rst_seq_pkg::WKFLAG_BIT],
        dat_i[4:0]};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pmc_q  <= rst_seq_pkg::PMC_RST_POR;
            misc_q <= rst_seq_pkg::MISC_RST_POR;
            nmi_q  <= rst_seq_pkg::NMI_RST;
        end
        else if (full_rst_w)
        begin
            pmc_q  <= rst_seq_pkg::PMC_RST_POR;
            misc_q <= (pin_rst_w & por_good_w & ~brown_w)
                    ? rst_seq_pkg::MISC_RST_PIN
                    : rst_seq_pkg::MISC_RST_POR;
            nmi_q  <= rst_seq_pkg::NMI_RST;
        end
        else
        begin
            if (state_q == rst_seq_pkg::ST_RUN & wdog_timeout_i)
                pmc_q <= rst_seq_pkg::PMC_RST_WDOG;
            else if (wake_rst_w)
                pmc_q <= rst_seq_pkg::PMC_RST_WAKE;
            else
            begin
                if (wr_pmc_w)
                    pmc_q[6:0] <= pmc_sw_w[6:0];
                if (wake_w)
                    pmc_q[rst_seq_pkg::WKFLAG_BIT] <= 1'b1;
                if (state_q == rst_seq_pkg::ST_SLEEP & ~wake_w)
                    pmc_q[rst_seq_pkg::PD_BIT] <= 1'b1;
                else if (wake_w)
                    pmc_q[rst_seq_pkg::PD_BIT] <= 1'b0;
                pmc_q[rst_seq_pkg::WARN_BIT] <=
                    ~(pad_low_w & pad_det_en_o);
            end
            if (wr_misc_w)
                misc_q[rst_seq_pkg::PINRST_BIT] <=
                    misc_q[rst_seq_pkg::PINRST_BIT]
                    & dat_i[rst_seq_pkg::PINRST_BIT];
            if (wr_nmi_w)
                nmi_q[rst_seq_pkg::NMIEN_BIT] <= dat_i[rst_seq_pkg::NMIEN_BIT];
            if (pad_low_w & pad_det_en_o)
                nmi_q[rst_seq_pkg::NMIFLAG_BIT] <= 1'b1;
            else if (wr_nmi_w)
                nmi_q[rst_seq_pkg::NMIFLAG_BIT] <=
                    nmi_q[rst_seq_pkg::NMIFLAG_BIT]
                    & dat_i[rst_seq_pkg::NMIFLAG_BIT];
        end
    end

    // ====================
    // Boot mode decode
    logic [1:0] boot_w;
    assign boot_w = straps_q[2] ? (straps_q[1] ? rst_seq_pkg::BOOT_JTAG
                                               : rst_seq_pkg::BOOT_USER)
                  : (~straps_q[1] ? rst_seq_pkg::BOOT_LOAD
                  : (~straps_q[0] ? rst_seq_pkg::BOOT_DEBUG
                                  : rst_seq_pkg::BOOT_LOAD));

    // ====================
    // Registered outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dat_o            <= 32'h00000000;
            ack_o            <= 1'b0;
            cpu_reset_o      <= 1'b1;
            start_addr_o     <= rst_seq_pkg::START_ADDR;
            boot_mode_o      <= rst_seq_pkg::BOOT_USER;
            main_reg_en_o    <= 1'b1;
            lp_reg_en_o      <= 1'b1;
            reg_reset_o      <= 1'b1;
            pll_out_en_o     <= 1'b0;
            pad_det_en_o     <= 1'b0;
            core_det_en_o    <= 1'b1;
            ports_tristate_o <= 1'b1;
            ram_valid_o      <= 1'b0;
            nmi_o            <= 1'b0;
            idle_exit_o      <= 1'b0;
            power_down_o     <= 1'b0;
        end
        else
        begin
            ack_o <= req_w;
            dat_o <= (req_w & hit_w & ~we_i) ? {24'h000000, rd_w}
                                             : 32'h00000000;
            cpu_reset_o  <= (state_d != rst_seq_pkg::ST_RUN)
                          & (state_d != rst_seq_pkg::ST_SLEEP);
            start_addr_o <= rst_seq_pkg::START_ADDR;
            boot_mode_o  <= boot_w;
            main_reg_en_o <= (state_d != rst_seq_pkg::ST_SLEEP);
            lp_reg_en_o   <= 1'b1;
            reg_reset_o   <= (state_d == rst_seq_pkg::ST_HOLD)
                           | (state_d == rst_seq_pkg::ST_REG);
            pll_out_en_o  <= osc_ok_w
                & ((state_d == rst_seq_pkg::ST_CLK)
                 | (state_d == rst_seq_pkg::ST_WDOG)
                 | (state_d == rst_seq_pkg::ST_RUN));
            pad_det_en_o  <= ~pad_3v3_w
                & (state_d != rst_seq_pkg::ST_SLEEP);
            core_det_en_o <= 1'b1;
            ports_tristate_o <= brown_w | ~por_good_w;
            ram_valid_o   <= ram_ok_q;
            nmi_o <= wdog_nmi_req_i
                   | (nmi_q[rst_seq_pkg::NMIFLAG_BIT]
                    & nmi_q[rst_seq_pkg::NMIEN_BIT]);
            idle_exit_o   <= pin_rst_w & idle_i;
            power_down_o  <= (state_d == rst_seq_pkg::ST_SLEEP);
        end
    end

endmodule // reset_control_and_wakeup

// ===== src/rst_seq_pkg.sv
// Package of constants for the reset and wake-up sequencer.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone slave.
package rst_seq_pkg;

    // ====================
    // Timing
    localparam int unsigned CLK_MHZ         = 100;
    localparam int unsigned REG_HOLD_US     = 300;
    localparam int unsigned REG_HOLD_CYCLES = REG_HOLD_US * CLK_MHZ;
    localparam int unsigned CLK_WAIT_CYCLES = 64;
    localparam int unsigned WDOG_RST_CYCLES = 16;
    localparam int unsigned CNT_W           = 16;

    // ====================
    // Register byte offsets
    localparam logic [7:0] PMC_OFS    = 8'h00;
    localparam logic [7:0] MISC_OFS   = 8'h04;
    localparam logic [7:0] NMI_OFS    = 8'h08;
    localparam logic [7:0] STAT_OFS   = 8'h0C;

    // ====================
    // power_mode_ctrl, misc and nmi register fields
    localparam int WS_LSB      = 0;
    localparam int SD_BIT      = 2;
    localparam int PD_BIT      = 3;
    localparam int WAKE_RESET_SEL_BIT   = 4;
    localparam int WKFLAG_BIT  = 5;
    localparam int WDFLAG_BIT  = 6;
    localparam int WARN_BIT    = 7;
    localparam int PINRST_BIT  = 0;
    localparam int NMIEN_BIT   = 0;
    localparam int NMIFLAG_BIT = 1;

    // Reset values by cause
    localparam logic [7:0] PMC_RST_POR  = 8'h80;
    localparam logic [7:0] PMC_RST_WDOG = 8'hC0;
    localparam logic [7:0] PMC_RST_WAKE = 8'hA0;
    localparam logic [7:0] MISC_RST_POR = 8'h00;
    localparam logic [7:0] MISC_RST_PIN = 8'h01;
    localparam logic [7:0] NMI_RST      = 8'h00;

    // Wake source codes
    localparam logic [1:0] WS_NONE = 2'h0;
    localparam logic [1:0] WS_RXD  = 2'h1;
    localparam logic [1:0] WS_EXT  = 2'h2;
    localparam logic [1:0] WS_BOTH = 2'h3;

    // Boot modes
    localparam logic [1:0] BOOT_USER  = 2'h0;
    localparam logic [1:0] BOOT_JTAG  = 2'h1;
    localparam logic [1:0] BOOT_LOAD  = 2'h2;
    localparam logic [1:0] BOOT_DEBUG = 2'h3;

    localparam logic [15:0] START_ADDR = 16'h0000;

    // Reset causes
    typedef enum logic [2:0]
    {
        CAUSE_POR  = 3'h0,
        CAUSE_PIN  = 3'h1,
        CAUSE_WDOG = 3'h2,
        CAUSE_WAKE = 3'h3,
        CAUSE_BOR  = 3'h4
    } cause_t;

    typedef enum logic [5:0]
    {
        ST_HOLD  = 6'b000001,
        ST_REG   = 6'b000010,
        ST_CLK   = 6'b000100,
        ST_WDOG  = 6'b001000,
        ST_RUN   = 6'b010000,
        ST_SLEEP = 6'b100000
    } state_t;

endpackage

// ===== test/reset_control_and_wakeup_monitor.sv
// Checker for the reset and wake-up sequencer, on top-level ports only.
// Assumes one clock, clk_i, and synchronous reset rst_i.
module reset_control_and_wakeup_monitor
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Bus
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        ack_o,
    input wire logic [31:0] dat_o,
    // Sequencer
    input wire logic        core_supply_low_i,
    input wire logic        wdog_nmi_req_i,
    input wire logic        nmi_o,
    input wire logic        cpu_reset_o,
    input wire logic        reg_reset_o,
    input wire logic        pll_out_en_o,
    input wire logic        ports_tristate_o,
    input wire logic [15:0] start_addr_o,
    input wire logic        main_reg_en_o,
    input wire logic        lp_reg_en_o,
    input wire logic        pad_det_en_o,
    input wire logic        core_det_en_o,
    input wire logic        power_down_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ====================
    // Assertions
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acknowledged next cycle");
    a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack cycle");
    a_start_addr: assert property (start_addr_o == 16'h0000)
        else $error("start address not zero");
    a_pd_regulators: assert property (power_down_o |-> !main_reg_en_o
        && lp_reg_en_o)
        else $error("regulator enables wrong in power-down");
    a_pd_detectors: assert property (power_down_o |-> !pad_det_en_o
        && core_det_en_o)
        else $error("detector enables wrong in power-down");
    a_pll_after_reg: assert property (pll_out_en_o |-> !reg_reset_o)
        else $error("PLL output on during regulator reset");
    a_cpu_held: assert property (reg_reset_o |-> cpu_reset_o)
        else $error("CPU released during regulator reset");
    a_bor_tristate: assert property (core_supply_low_i [*4]
        |-> ports_tristate_o && cpu_reset_o)
        else $error("brownout without tristate or reset");
    a_wdog_nmi: assert property (wdog_nmi_req_i [*3] |-> nmi_o)
        else $error("watchdog request not forwarded");
    c_run: cover property ($fell(cpu_reset_o));
    c_power_down: cover property ($fell(power_down_o));
    c_brownout: cover property (core_supply_low_i && ports_tristate_o);
endmodule // reset_control_and_wakeup_monitor

bind reset_control_and_wakeup reset_control_and_wakeup_monitor monitor_inst
(
    .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .dat_o, .core_supply_low_i,
    .wdog_nmi_req_i, .nmi_o, .cpu_reset_o, .reg_reset_o, .pll_out_en_o,
    .ports_tristate_o, .start_addr_o, .main_reg_en_o, .lp_reg_en_o,
    .pad_det_en_o, .core_det_en_o, .power_down_o
);

// ===== test/reset_control_and_wakeup_tb_top.sv
// Self-checking bench for the reset and wake-up sequencer.
// Assumes full-length regulator hold; run about 60000 cycles.
module reset_control_and_wakeup_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic pad_supply_low_i = 0, pad_is_3v3_i = 0, osc_running_i = 1;
    logic clk_stable_i = 1, boot_mode_pin_i = 1, tms_pin_i = 1;
    logic boot_select_pin_zero_i = 1, rxd_i = 1, ext_irq_zero_input_i = 1;
    logic wdog_nmi_req_i = 0, wdog_timeout_i = 0, idle_i = 0;
    logic pin_req = 0, bor_req = 0, reg_seen = 0, ack_o, cpu_reset_o;
    logic ext_reset_n_i, por_good_i, core_supply_low_i, main_reg_en_o;
    logic lp_reg_en_o, reg_reset_o, pll_out_en_o, pad_det_en_o, nmi_o;
    logic core_det_en_o, ports_tristate_o, ram_valid_o, power_down_o;
    logic idle_exit_o;
    logic [15:0] start_addr_o;
    logic [1:0] boot_mode_o, ws;
    int bad_count = 0, checked = 0, n, pmc_m;
    integer seed = 32'hd102;
    reset_control_and_wakeup reset_control_and_wakeup_inst (.*);
    supply_pins_model supply_pins_model_inst (.clk_i, .pin_req_i(pin_req),
        .bor_req_i(bor_req), .ext_reset_n_o(ext_reset_n_i),
        .por_good_o(por_good_i), .core_supply_low_o(core_supply_low_i));
    initial
        forever #5 clk_i = ~clk_i;
    always @(posedge clk_i)
        if (reg_reset_o === 1'b1)
            reg_seen <= 1'b1;
    // ====================
    // Tasks
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            $display("MISMATCH %s exp %h got %h", s, e, g);
            bad_count++;
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (ack_o !== 1'b1 && k < 50);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        chk("ack", 32'h1, 32'(k < 50));
    endtask
    task rdc(input string s, input logic [7:0] a, input int e);
        wb(1'b0, a, 8'h00);
        chk(s, 32'(e), rd);
    endtask
    task wait_run();
        n = 0;
        while (cpu_reset_o !== 1'b0 && n < 40000)
        begin
            @(posedge clk_i);
            n++;
        end
        @(posedge clk_i);
    endtask
    function automatic int st(logic [1:0] b, logic [2:0] c, logic r);
        return int'({r, c, b});
    endfunction
    task finish_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #900000;
        bad_count++;
        finish_test();
    end
    // ====================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_run();
        chk("reg_hold", 32'h1, 32'(n >= rst_seq_pkg::REG_HOLD_CYCLES));
        chk("outs", 32'h2, 32'({cpu_reset_o, reg_reset_o, pll_out_en_o,
            ports_tristate_o}));
        chk("boot", 32'(rst_seq_pkg::BOOT_JTAG), 32'(boot_mode_o));
        rdc("pmc", rst_seq_pkg::PMC_OFS, rst_seq_pkg::PMC_RST_POR);
        rdc("misc", rst_seq_pkg::MISC_OFS, rst_seq_pkg::MISC_RST_POR);
        rdc("stat", rst_seq_pkg::STAT_OFS, st(rst_seq_pkg::BOOT_JTAG,
            rst_seq_pkg::CAUSE_POR, 1'b0));
        rdc("unmapped", 8'h10, 0);
        boot_mode_pin_i <= 1'($random(seed));
        tms_pin_i <= 1'($random(seed));
        pad_is_3v3_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk("boot_frozen", 32'(rst_seq_pkg::BOOT_JTAG), 32'(boot_mode_o));
        chk("pad_det_3v3", 32'h0, 32'(pad_det_en_o));
        pad_is_3v3_i <= 1'b0;
        $display("test power_on done");
        wdog_nmi_req_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk("wdog_nmi", 32'h1, 32'(nmi_o));
        wdog_nmi_req_i <= 1'b0;
        wdog_timeout_i <= 1'b1;
        reg_seen = 1'b0;
        @(posedge clk_i);
        wdog_timeout_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("wdog_cpu_rst", 32'h1, 32'(cpu_reset_o));
        wait_run();
        chk("wdog_short", 32'h1, 32'(n < 100 && reg_seen == 1'b0));
        rdc("pmc_wdog", rst_seq_pkg::PMC_OFS, rst_seq_pkg::PMC_RST_WDOG);
        rdc("stat_wdog", rst_seq_pkg::STAT_OFS, st(rst_seq_pkg::BOOT_JTAG,
            rst_seq_pkg::CAUSE_WDOG, 1'b1));
        $display("test watchdog done");
        pad_supply_low_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk("nmi_masked", 32'h0, 32'(nmi_o));
        rdc("nmi_flag", rst_seq_pkg::NMI_OFS, 2);
        rdc("pmc_warn", rst_seq_pkg::PMC_OFS, 32'h40);
        wb(1'b1, rst_seq_pkg::NMI_OFS, 8'h01);
        repeat (3) @(posedge clk_i);
        chk("nmi_on", 32'h1, 32'(nmi_o));
        pad_supply_low_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        wb(1'b1, rst_seq_pkg::NMI_OFS, 8'h00);
        rdc("nmi_clear", rst_seq_pkg::NMI_OFS, 0);
        $display("test supply_warning done");
        ws = ($random(seed) & 1) ? rst_seq_pkg::WS_RXD : rst_seq_pkg::WS_BOTH;
        pmc_m = 8'h08 | int'(ws);
        wb(1'b1, rst_seq_pkg::PMC_OFS, 8'(pmc_m));
        repeat (4) @(posedge clk_i);
        chk("pd_outs", 32'h15, 32'({power_down_o, main_reg_en_o, lp_reg_en_o,
            pad_det_en_o, core_det_en_o}));
        rxd_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk("woken", 32'h0, 32'({power_down_o, cpu_reset_o}));
        rdc("pmc_wake", rst_seq_pkg::PMC_OFS, 32'hE0 & ~32'h40 | ws);
        rxd_i <= 1'b1;
        $display("test wake done");
        boot_mode_pin_i <= 1'b0;
        tms_pin_i <= 1'b0;
        idle_i <= 1'b1;
        pin_req <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk("pin_outs", 32'h3, 32'({cpu_reset_o, idle_exit_o}));
        pin_req <= 1'b0;
        idle_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        wait_run();
        chk("pin_seq", 32'h1, 32'(n >= rst_seq_pkg::REG_HOLD_CYCLES));
        chk("boot_load", 32'(rst_seq_pkg::BOOT_LOAD), 32'(boot_mode_o));
        rdc("misc_pin", rst_seq_pkg::MISC_OFS, rst_seq_pkg::MISC_RST_PIN);
        rdc("pmc_pin", rst_seq_pkg::PMC_OFS, rst_seq_pkg::PMC_RST_POR);
        rdc("stat_pin", rst_seq_pkg::STAT_OFS, st(rst_seq_pkg::BOOT_LOAD,
            rst_seq_pkg::CAUSE_PIN, 1'b1));
        wb(1'b1, rst_seq_pkg::MISC_OFS, 8'h00);
        rdc("misc_clear", rst_seq_pkg::MISC_OFS, 0);
        $display("test pin_reset done");
        bor_req <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk("bor_outs", 32'h7, 32'({ports_tristate_o, cpu_reset_o,
            reg_reset_o}));
        $display("test brownout done");
        finish_test();
    end
endmodule // reset_control_and_wakeup_tb_top

// ===== test/supply_pins_model.sv
// Far-side model: reset pin, power-on detector and brownout detector.
// Assumes the bench raises pin_req_i and bor_req_i on clk_i.
module supply_pins_model
(
    input  wire logic clk_i,
    input  wire logic pin_req_i,
    input  wire logic bor_req_i,
    output logic      ext_reset_n_o,
    output logic      por_good_o,
    output logic      core_supply_low_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int unsigned ramp_q = 0;
    initial
    begin
        ext_reset_n_o = 1'b1;
        por_good_o = 1'b0;
        core_supply_low_o = 1'b0;
    end
    always @(posedge clk_i)
    begin
        if (ramp_q < 8)
            ramp_q <= ramp_q + 1;
        por_good_o <= ramp_q >= 8;
        ext_reset_n_o <= !pin_req_i;
        core_supply_low_o <= bor_req_i;
    end
endmodule // supply_pins_model
